/* File: logic/fcp_consts.svh */
// Offsets, field positions, reset values and timing counts of the loader
`ifndef FCP_CONSTS_SVH
`define FCP_CONSTS_SVH
`define FCP_CTRL_OFS    12'h000
`define FCP_STAT_OFS    12'h004
`define FCP_CTRL_RST    32'h0010_0000
`define FCP_CTRL_MASK   32'hFFFF_006F
`define FCP_WSEL_LSB    0
`define FCP_SINGLE_BIT  3
`define FCP_REMOTE_BIT  4
`define FCP_RIMG_LSB    5
`define FCP_WORDS_LSB   16
`define FCP_CLK_NS      25
`define FCP_HALF_NS     100
`define FCP_HALF_CYC    8'((`FCP_HALF_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS)
`define FCP_CMD_READ    8'h03
`define FCP_CMD_LAST    4'h7
`define FCP_WORD_BITS   6'h20
`define FCP_IR_CAPTURE  4'h1
`define FCP_IR_IDCODE   4'h1
`define FCP_IR_STATUS   4'h2
`define FCP_IR_BYPASS   4'hF
`endif

/* File: logic/fcp_pkg.sv */
// Types and shared helpers of the configuration pin loader
package fcp_pkg;
  typedef enum logic [5:0] {
    LD_HOLD = 6'h01, LD_CMD = 6'h02, LD_LOAD = 6'h04,
    LD_REL  = 6'h08, LD_USER = 6'h10, LD_FAIL = 6'h20
  } fcp_ld_t;
  typedef enum logic [15:0] {
    TP_RESET  = 16'h0001, TP_IDLE   = 16'h0002, TP_SEL_DR = 16'h0004,
    TP_CAP_DR = 16'h0008, TP_SH_DR  = 16'h0010, TP_EX1_DR = 16'h0020,
    TP_PAU_DR = 16'h0040, TP_EX2_DR = 16'h0080, TP_UPD_DR = 16'h0100,
    TP_SEL_IR = 16'h0200, TP_CAP_IR = 16'h0400, TP_SH_IR  = 16'h0800,
    TP_EX1_IR = 16'h1000, TP_PAU_IR = 16'h2000, TP_EX2_IR = 16'h4000,
    TP_UPD_IR = 16'h8000
  } fcp_tap_st_t;
  typedef struct packed {
    fcp_tap_st_t st;
    logic        tck_q;
    logic [3:0]  ir;
    logic [3:0]  irs;
    logic [31:0] dr;
    logic        tdo;
    logic        tdo_oe;
  } fcp_tap_t;
  typedef struct packed {
    fcp_ld_t     st;
    logic        crst_q;
    logic        cclk_q;
    logic        mode_act;
    logic        remote;
    logic [1:0]  image;
    logic [2:0]  wsel;
    logic [31:0] ctrl;
    logic [31:0] word;
    logic [31:0] xacc;
    logic [5:0]  bitcnt;
    logic [15:0] widx;
    logic [7:0]  div;
    logic [3:0]  cmdcnt;
    logic [7:0]  cmd;
    logic        cclk_o;
    logic        cclk_oe;
    logic [31:0] lane_o;
    logic [31:0] lane_oe;
    logic        done_o;
    logic        done_oe;
    logic        err_n;
    logic        err_id;
    logic        err_crc;
    logic        err_rem;
    logic        user;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fcp_top_t;
  // Active lane count for a width code; codes 6 and 7 act as 32 lanes
  function automatic logic [5:0] fcp_lanes(input logic [2:0] ws);
    case (ws)
      3'h0:    return 6'h01;
      3'h1:    return 6'h02;
      3'h2:    return 6'h04;
      3'h3:    return 6'h08;
      3'h4:    return 6'h10;
      default: return 6'h20;
    endcase
  endfunction
  // Shift a word left by the lane count and merge the new lanes
  function automatic logic [31:0] fcp_pack(input logic [31:0] w,
                                           input logic [31:0] d,
                                           input logic [2:0]  ws);
    logic [31:0] m;
    m = (32'h1 << fcp_lanes(ws)) - 32'h1;
    return (w << fcp_lanes(ws)) | (d & m);
  endfunction
endpackage

/* File: logic/fcp_sync.sv */
// Two-stage synchroniser for pins with a settable reset level
`timescale 1ns/1ps
module fcp_sync #(
  parameter int           W  = 1,
  parameter logic [W-1:0] RV = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] m;
    logic [W-1:0] q;
  } sync_t;
  sync_t r_ff;
  sync_t nxt_r;

  // First stage feeds only the second stage
  always_comb begin
    nxt_r.m = d;
    nxt_r.q = r_ff.m;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r_ff <= {RV, RV};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign q = r_ff.q;
endmodule

/* File: logic/fcp_tap.sv */
// Test access port sampled on the system clock
`timescale 1ns/1ps
module fcp_tap import fcp_pkg::*; #(
  parameter logic [31:0] ID_CODE = 32'h1234_5679  // Arbitrary value
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       tck_s,
  input  wire logic       tms_s,
  input  wire logic       tdi_s,
  input  wire logic [7:0] status,
  output logic            tdo,
  output logic            tdo_oe
);
`include "fcp_consts.svh"
  fcp_tap_t r_ff;
  fcp_tap_t nxt_r;
  logic     rise;
  logic     fall;
  logic [4:0] top;

  // Edges of the test clock, found from the synchronised copy
  assign rise = tck_s & ~r_ff.tck_q;
  assign fall = ~tck_s & r_ff.tck_q;

  // Length of the selected data path, minus one
  always_comb begin
    if (r_ff.ir == `FCP_IR_IDCODE) top = 5'h1F;
    else if (r_ff.ir == `FCP_IR_STATUS) top = 5'h07;
    else top = 5'h00;
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.tck_q = tck_s;
    if (rise) begin
      // Inputs taken at the rising test clock edge
      unique case (r_ff.st)
        TP_RESET:  nxt_r.ir = `FCP_IR_IDCODE;
        TP_CAP_IR: nxt_r.irs = `FCP_IR_CAPTURE;
        TP_SH_IR:  nxt_r.irs = {tdi_s, r_ff.irs[3:1]};
        TP_UPD_IR: nxt_r.ir = r_ff.irs;
        TP_CAP_DR: begin
          if (r_ff.ir == `FCP_IR_IDCODE) nxt_r.dr = ID_CODE;
          else if (r_ff.ir == `FCP_IR_STATUS) nxt_r.dr = {24'h0, status};
          else nxt_r.dr = 32'h0000_0000;
        end
        TP_SH_DR: begin
          nxt_r.dr = r_ff.dr >> 1;
          nxt_r.dr[top] = tdi_s;
        end
        default: ;
      endcase
      unique case (r_ff.st)
        TP_RESET:  nxt_r.st = tms_s ? TP_RESET  : TP_IDLE;
        TP_IDLE:   nxt_r.st = tms_s ? TP_SEL_DR : TP_IDLE;
        TP_SEL_DR: nxt_r.st = tms_s ? TP_SEL_IR : TP_CAP_DR;
        TP_CAP_DR: nxt_r.st = tms_s ? TP_EX1_DR : TP_SH_DR;
        TP_SH_DR:  nxt_r.st = tms_s ? TP_EX1_DR : TP_SH_DR;
        TP_EX1_DR: nxt_r.st = tms_s ? TP_UPD_DR : TP_PAU_DR;
        TP_PAU_DR: nxt_r.st = tms_s ? TP_EX2_DR : TP_PAU_DR;
        TP_EX2_DR: nxt_r.st = tms_s ? TP_UPD_DR : TP_SH_DR;
        TP_UPD_DR: nxt_r.st = tms_s ? TP_SEL_DR : TP_IDLE;
        TP_SEL_IR: nxt_r.st = tms_s ? TP_RESET  : TP_CAP_IR;
        TP_CAP_IR: nxt_r.st = tms_s ? TP_EX1_IR : TP_SH_IR;
        TP_SH_IR:  nxt_r.st = tms_s ? TP_EX1_IR : TP_SH_IR;
        TP_EX1_IR: nxt_r.st = tms_s ? TP_UPD_IR : TP_PAU_IR;
        TP_PAU_IR: nxt_r.st = tms_s ? TP_EX2_IR : TP_PAU_IR;
        TP_EX2_IR: nxt_r.st = tms_s ? TP_UPD_IR : TP_SH_IR;
        TP_UPD_IR: nxt_r.st = tms_s ? TP_SEL_DR : TP_IDLE;
        default:   nxt_r.st = TP_RESET;
      endcase
    end
    if (fall) begin
      // Output moves on the falling edge, driven only while shifting
      nxt_r.tdo = (r_ff.st == TP_SH_IR) ? r_ff.irs[0] : r_ff.dr[0];
      nxt_r.tdo_oe = (r_ff.st == TP_SH_IR) | (r_ff.st == TP_SH_DR);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r_ff <= '{st: TP_RESET, ir: `FCP_IR_IDCODE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign tdo    = r_ff.tdo;
  assign tdo_oe = r_ff.tdo_oe;
endmodule

/* File: logic/fcp_top.sv */
// Configuration pin loader: reset trigger, serial load, done flag, TAP
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
module fcp_top import fcp_pkg::*; #(
  parameter logic [31:0] ID_WORD = 32'h5A5A_0001,  // Arbitrary value
  parameter logic [31:0] ID_CODE = 32'h1234_5679   // Arbitrary value
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        config_reset_n,
  input  wire logic        serial_mode_select_n,
  input  wire logic [1:0]  image_select,
  input  wire logic        config_serial_clock_i,
  output logic             config_serial_clock_o,
  output logic             config_serial_clock_oe,
  input  wire logic [31:0] config_data_lane_i,
  output logic      [31:0] config_data_lane_o,
  output logic      [31:0] config_data_lane_oe,
  input  wire logic        config_done_flag_i,
  output logic             config_done_flag_o,
  output logic             config_done_flag_oe,
  output logic             config_error_n,
  output logic             user_io_en,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdo_oe
);
`include "fcp_consts.svh"

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int SW = 41;
  // Pulled-up pins come out of reset as one; the test clock has no pull-up
  localparam logic [SW-1:0] SRV = {1'h0, 2'h3, 1'h1, 1'h1, 2'h0, 1'h0, 1'h0, 32'h0};

  logic [SW-1:0] sy;
  logic          tck_s;
  logic          tms_s;
  logic          tdi_s;
  logic          crst_s;
  logic          ssl_s;
  logic [1:0]    img_s;
  logic          cclk_s;
  logic          done_s;
  logic [31:0]   lane_s;

  // Loader state, declared ahead of the TAP that reports it
  fcp_top_t      r_ff;
  fcp_top_t      nxt_r;

  fcp_sync #(
    .W  (SW),
    .RV (SRV)
  ) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       ({tck, tms, tdi, config_reset_n, serial_mode_select_n,
                image_select, config_serial_clock_i, config_done_flag_i,
                config_data_lane_i}),
    .q       (sy)
  );

  // Split the synchronised bundle
  assign {tck_s, tms_s, tdi_s, crst_s, ssl_s, img_s, cclk_s, done_s,
          lane_s} = sy;

  ////////////////////////////////////////////////////////////////////////
  // Test access port

  // Weak pull-ups mean an open input reads one
  fcp_tap #(
    .ID_CODE (ID_CODE)
  ) u_tap (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tck_s   (tck_s),
    .tms_s   (tms_s),
    .tdi_s   (tdi_s),
    .status  ({r_ff.st[5:0], r_ff.user, r_ff.err_n}),
    .tdo     (tdo),
    .tdo_oe  (tdo_oe)
  );

  ////////////////////////////////////////////////////////////////////////
  // Loader working signals

  logic        acc;
  logic        hit;
  logic        wr;
  logic [31:0] rd;
  logic        start;
  logic        go_remote;
  logic [31:0] cfg;
  logic        tick;
  logic        g_rise;
  logic        g_fall;
  logic        bit_ev;
  logic [31:0] din;
  logic [31:0] wnext;
  logic [5:0]  bsum;
  logic [15:0] words;

  ////////////////////////////////////////////////////////////////////////
  // Register bus decode

  assign acc   = psel & penable;
  assign hit   = (paddr == `FCP_CTRL_OFS) | (paddr == `FCP_STAT_OFS);
  assign wr    = acc & r_ff.pready & pwrite & (paddr == `FCP_CTRL_OFS);
  assign words = r_ff.ctrl[`FCP_WORDS_LSB +: 16];

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd = 32'h0000_0000;
    if (paddr == `FCP_CTRL_OFS) begin
      rd = r_ff.ctrl;
    end else if (paddr == `FCP_STAT_OFS) begin
      rd = {16'h0000, r_ff.widx[5:0], r_ff.st, r_ff.user,
            r_ff.err_rem, r_ff.err_crc, r_ff.err_id};
      rd[31:28] = {r_ff.mode_act, r_ff.remote, r_ff.image};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pass triggers and serial clock events

  // A pin pass starts only on the rising reset edge
  assign start = ~r_ff.crst_q & crst_s;
  // Software reload is taken only from user mode
  assign go_remote = wr & pwdata[`FCP_REMOTE_BIT] & (r_ff.st == LD_USER);
  // A reload takes width and image from the very word that starts it
  assign cfg = go_remote ? (pwdata & `FCP_CTRL_MASK) : r_ff.ctrl;

  // Own clock divider, ticking only while fetching
  assign tick   = r_ff.mode_act & (r_ff.st == LD_CMD | r_ff.st == LD_LOAD)
                  & (r_ff.div == `FCP_HALF_CYC - 8'h01);
  assign g_rise = tick & ~r_ff.cclk_o;
  assign g_fall = tick & r_ff.cclk_o;

  // Host clock edge, found from the synchronised copy
  assign bit_ev = r_ff.mode_act ? g_rise : (~r_ff.cclk_q & cclk_s);

  // Single lane active mode reads data back on lane 1
  assign din = (r_ff.mode_act && r_ff.wsel == 3'h0) ?
               {31'h0, lane_s[1]} : lane_s;
  assign wnext = fcp_pack(r_ff.word, din, r_ff.wsel);
  assign bsum  = r_ff.bitcnt + fcp_lanes(r_ff.wsel);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    nxt_r = r_ff;
    nxt_r.crst_q = crst_s;
    nxt_r.cclk_q = cclk_s;
    nxt_r.done_o = 1'b0;

    // Bus answer: one wait cycle, then a one-cycle ready
    nxt_r.pready  = 1'b0;
    nxt_r.pslverr = 1'b0;
    if (acc & ~r_ff.pready) begin
      nxt_r.pready  = 1'b1;
      nxt_r.pslverr = ~hit;
      nxt_r.prdata  = rd;
    end
    if (wr) begin
      nxt_r.ctrl = pwdata & `FCP_CTRL_MASK;
    end

    // Divider runs while the device makes the clock
    if (tick) begin
      nxt_r.div    = 8'h00;
      nxt_r.cclk_o = ~r_ff.cclk_o;
    end else if (r_ff.mode_act) begin
      nxt_r.div = r_ff.div + 8'h01;
    end

    unique case (r_ff.st)
      LD_HOLD: ;
      LD_CMD: begin
        // Read opcode out on lane 0, and on lane 4 in x8
        if (g_fall) begin
          nxt_r.lane_o[0] = r_ff.cmd[7];
          nxt_r.lane_o[4] = r_ff.cmd[7];
          nxt_r.cmd = {r_ff.cmd[6:0], 1'b0};
        end
        if (g_rise) begin
          nxt_r.cmdcnt = r_ff.cmdcnt + 4'h1;
          if (r_ff.cmdcnt == `FCP_CMD_LAST) begin
            nxt_r.st = LD_LOAD;
            // Lane 0 stays an output only in x1
            nxt_r.lane_oe[0] = (r_ff.wsel == 3'h0);
            nxt_r.lane_oe[4] = 1'b0;
          end
        end
      end
      LD_LOAD: begin
        if (bit_ev) begin
          nxt_r.word   = wnext;
          nxt_r.bitcnt = bsum;
          if (bsum == `FCP_WORD_BITS) begin
            nxt_r.bitcnt = 6'h00;
            nxt_r.widx   = r_ff.widx + 16'h0001;
            if (r_ff.widx == 16'h0000) begin
              // Header must carry this device's identity
              if (wnext != ID_WORD) begin
                nxt_r.st     = LD_FAIL;
                nxt_r.err_id = 1'b1;
              end
            end else if (r_ff.widx <= words) begin
              nxt_r.xacc = r_ff.xacc ^ wnext;
            end else if (wnext != r_ff.xacc) begin
              nxt_r.st      = LD_FAIL;
              nxt_r.err_crc = 1'b1;
            end else begin
              // Image good: release the done line
              nxt_r.st      = LD_REL;
              nxt_r.done_oe = 1'b0;
            end
          end
        end
      end
      LD_REL: begin
        // Wait for the wired line; others may hold it low
        if (done_s) begin
          nxt_r.st   = LD_USER;
          nxt_r.user = 1'b1;
        end
      end
      LD_USER: ;
      LD_FAIL: ;
      default: nxt_r.st = LD_HOLD;
    endcase

    // Lane drivers and clock driver are off outside the fetch
    if (nxt_r.st != LD_CMD && nxt_r.st != LD_LOAD) begin
      nxt_r.lane_oe = 32'h0000_0000;
      nxt_r.cclk_oe = 1'b0;
    end

    // Failed pass: error pin low, remote flag if software asked
    if (nxt_r.st == LD_FAIL && r_ff.st != LD_FAIL) begin
      nxt_r.err_n   = 1'b0;
      nxt_r.err_rem = r_ff.remote;
    end

    // Reset pin low: hold, drive done low; bus registers untouched
    if (!crst_s) begin
      nxt_r.st      = LD_HOLD;
      nxt_r.done_oe = 1'b1;
      nxt_r.user    = 1'b0;
      nxt_r.lane_oe = 32'h0000_0000;
      nxt_r.cclk_oe = 1'b0;
    end

    // New pass from the reset pin or from a software reload
    if (start | go_remote) begin
      nxt_r.remote  = go_remote;
      nxt_r.wsel    = cfg[`FCP_WSEL_LSB +: 3];
      nxt_r.word    = 32'h0000_0000;
      nxt_r.xacc    = 32'h0000_0000;
      nxt_r.bitcnt  = 6'h00;
      nxt_r.widx    = 16'h0000;
      nxt_r.div     = 8'h00;
      nxt_r.cmdcnt  = 4'h0;
      nxt_r.cclk_o  = 1'b0;
      nxt_r.err_n   = 1'b1;
      nxt_r.err_id  = 1'b0;
      nxt_r.err_crc = 1'b0;
      nxt_r.err_rem = 1'b0;
      nxt_r.user    = 1'b0;
      nxt_r.done_oe = 1'b1;
      // Software reload keeps the old mode
      if (start) begin
        nxt_r.mode_act = ssl_s;
      end
      // Image chosen once for the whole pass
      if (go_remote) begin
        nxt_r.image = cfg[`FCP_RIMG_LSB +: 2];
      end else if (r_ff.ctrl[`FCP_SINGLE_BIT]) begin
        nxt_r.image = 2'h0;
      end else begin
        nxt_r.image = img_s;
      end
      if (go_remote ? r_ff.mode_act : ssl_s) begin
        // Active: drive clock and opcode lanes
        nxt_r.st        = LD_CMD;
        nxt_r.cclk_oe   = 1'b1;
        nxt_r.cmd       = {`FCP_CMD_READ} << 1;
        nxt_r.lane_o    = 32'h0000_0000;
        nxt_r.lane_o[0] = 1'(`FCP_CMD_READ >> 7);
        nxt_r.lane_o[4] = 1'(`FCP_CMD_READ >> 7);
        nxt_r.lane_oe   = 32'h0000_0000;
        nxt_r.lane_oe[0] = 1'b1;
        nxt_r.lane_oe[4] = (cfg[`FCP_WSEL_LSB +: 3] == 3'h3);
      end else begin
        // Passive: host owns clock and every lane
        nxt_r.st      = LD_LOAD;
        nxt_r.cclk_oe = 1'b0;
        nxt_r.lane_oe = 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      // Reset pin copy starts high like its synchroniser: no false start
      r_ff <= '{st: LD_HOLD, done_oe: 1'b1, err_n: 1'b1, crst_q: 1'b1,
                ctrl: `FCP_CTRL_RST, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign prdata                 = r_ff.prdata;
  assign pready                 = r_ff.pready;
  assign pslverr                = r_ff.pslverr;
  assign config_serial_clock_o  = r_ff.cclk_o;
  assign config_serial_clock_oe = r_ff.cclk_oe;
  assign config_data_lane_o     = r_ff.lane_o;
  assign config_data_lane_oe    = r_ff.lane_oe;
  assign config_done_flag_o     = r_ff.done_o;
  assign config_done_flag_oe    = r_ff.done_oe;
  assign config_error_n         = r_ff.err_n;
  // Covers dual-purpose pins only; test and reset pins stay put
  assign user_io_en             = r_ff.user;

endmodule

/* File: dv/fcp_props.sv */
// Port checker of the configuration pin loader
`timescale 1ns/1ps
module fcp_props (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        config_reset_n,
  input wire logic        serial_mode_select_n,
  input wire logic        config_serial_clock_oe,
  input wire logic [31:0] config_data_lane_oe,
  input wire logic        config_done_flag_i,
  input wire logic        config_done_flag_o,
  input wire logic        config_done_flag_oe,
  input wire logic        config_error_n,
  input wire logic        user_io_en,
  input wire logic        tck,
  input wire logic        tdo,
  input wire logic        tdo_oe
);
  logic       tck_d_ff;
  logic [7:0] gap_ff;
  // Cycles since the test clock moved; test outputs only follow it
  always_ff @(posedge clk_sys) begin
    tck_d_ff <= tck;
    if (!rstn || tck != tck_d_ff) gap_ff <= 8'h00;
    else if (gap_ff != 8'hFF) gap_ff <= gap_ff + 8'h01;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  a_done_od: assert property (config_done_flag_o == 1'b0)
    else $error("done pin driven high");
  a_user_gate: assert property ($rose(user_io_en) |->
    !config_done_flag_oe && $past(config_done_flag_i)) else $error("user mode too early");
  a_reset_holds: assert property ($fell(config_reset_n) |->
    ##[1:6] (config_done_flag_oe && !user_io_en)) else $error("pin reset ignored");
  a_tdo_edge: assert property ($changed(tdo) |-> gap_ff < 8'h07)
    else $error("tdo moved without tck");
  a_tdo_release: assert property ($changed(tdo_oe) |-> gap_ff < 8'h07)
    else $error("tdo enable moved without tck");
  a_clk_passive: assert property ($rose(config_reset_n) && !serial_mode_select_n |->
    ##6 !config_serial_clock_oe [*8]) else $error("clock driven in passive mode");
  a_lanes_passive: assert property ($rose(config_reset_n) && !serial_mode_select_n |->
    ##6 (config_data_lane_oe == 32'h0) [*8]) else $error("lanes driven in passive mode");
  a_err_gate: assert property ($fell(config_error_n) |-> config_done_flag_oe)
    else $error("error with done released");
  a_apb_wait: assert property (psel && !penable |-> ##1 !pready ##1 pready)
    else $error("apb answer late");
  a_slverr_map: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("apb error wrong");
  c_user: cover property ($rose(user_io_en));
  c_err: cover property ($fell(config_error_n));
  c_shift: cover property ($rose(tdo_oe));
endmodule
bind fcp_top fcp_props u_fcp_props (.clk_sys, .rstn, .paddr, .psel, .penable, .pready,
  .pslverr, .config_reset_n, .serial_mode_select_n, .config_serial_clock_oe,
  .config_data_lane_oe, .config_done_flag_i, .config_done_flag_o, .config_done_flag_oe,
  .config_error_n, .user_io_en, .tck, .tdo, .tdo_oe);

/* File: dv/fcp_host.sv */
// Passive configuration host and the wired done line
`timescale 1ns/1ps
module fcp_host #(
  parameter logic [31:0] ID_WORD = 32'h5A5A_0001  // Arbitrary value
) (
  input  wire logic        done_oe,
  input  wire logic        hold,
  output logic             cclk,
  output logic      [31:0] lanes,
  output logic             done_i
);
  // Pull-up line, low while either party pulls it
  assign done_i = !done_oe && !hold;
  initial begin
    cclk = 1'b0;
    lanes = 32'h0;
  end
  // One word, top group first, data moved on the falling edge
  task automatic word(input logic [31:0] w, input int n);
    for (int k = 32 - n; k >= 0; k -= n) begin
      lanes = 32'((64'(w) >> k) & ((64'h1 << n) - 64'h1));
      #100 cclk = 1'b1;
      #100 cclk = 1'b0;
    end
    lanes = ~lanes; // Stale data never lingers on the lanes
  endtask
  // Kind 1 spoils the id word, kind 2 the check word
  task automatic frame(input int n, input int nw, input int kind);
    logic [31:0] x;
    logic [31:0] p;
    x = 32'h0;
    #7;
    word(kind == 1 ? ~ID_WORD : ID_WORD, n);
    repeat (nw) begin
      p = $urandom;
      x ^= p;
      word(p, n);
    end
    word(kind == 2 ? ~x : x, n);
    // Clock keeps running for 100 cycles after the frame
    repeat (100) begin
      #100 cclk = 1'b1;
      #100 cclk = 1'b0;
    end
  endtask
endmodule

/* File: dv/fcp_top_bench.sv */
// Self-checking bench of the configuration pin loader
`timescale 1ns/1ps
module fcp_top_bench;
  localparam logic [31:0] ID_C = 32'h1234_5679;  // Arbitrary value
  logic        clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, lane_oe, lanes, rd, id;
  logic        pready, pslverr, cclk_oe, cclk, done_oe, done_i, err_n, user, tdo, tdo_oe;
  logic        crst_n = 1'b0, mode_n = 1'b0, hold = 1'b0, er, tbit;
  logic        tck = 1'b0, tms = 1'b1, tdi = 1'b1;
  logic [1:0]  img = 2'h0;
  int          n_fail = 0;
  int          num_checks = 0;
  int          act[2] = '{0, 3};
  always #12.5 clk_sys = ~clk_sys;
  fcp_top #(.ID_CODE(ID_C)) u_fcp_top (.clk_sys, .rstn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .config_reset_n(crst_n),
    .serial_mode_select_n(mode_n), .image_select(img), .config_serial_clock_i(cclk),
    .config_serial_clock_o(), .config_serial_clock_oe(cclk_oe), .config_data_lane_i(lanes),
    .config_data_lane_o(), .config_data_lane_oe(lane_oe), .config_done_flag_i(done_i),
    .config_done_flag_o(), .config_done_flag_oe(done_oe), .config_error_n(err_n),
    .user_io_en(user), .tck, .tms, .tdi, .tdo, .tdo_oe);
  fcp_host u_fcp_host (.done_oe, .hold, .cclk, .lanes, .done_i);
  ////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Bounded wait; running out ends the run
  task automatic waitv(ref logic s, input logic v);
    for (int k = 0; k < 400 && s !== v; k++) @(posedge clk_sys);
    if (s !== v) begin
      chk("wait", s, v);
      results();
    end
  endtask
  // One APB transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", pready, 1);
      results();
    end
  endtask
  task automatic pulse();
    crst_n <= 1'b0;
    cyc(8);
    crst_n <= 1'b1;
    cyc(8);
  endtask
  // One passive pass; done held low by us until the data is in
  task automatic pass(input logic [2:0] wc, input int kind, input logic one);
    int nw;
    logic [1:0] im;
    nw = 1 + $urandom % 3;
    im = 2'($urandom);
    apb(1'b1, 12'h000, {16'(nw), 12'h000, one, wc});
    img <= im;
    pulse();
    img <= ~im;
    hold <= 1'b1;
    u_fcp_host.frame(1 << wc, nw, kind);
    @(posedge clk_sys);
    chk("user held", user, 0);
    chk("done oe", done_oe, kind != 0);
    chk("error", err_n, kind == 0);
    hold <= 1'b0;
    if (kind == 0) waitv(user, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk("image", rd[29:28], one ? 2'h0 : im);
  endtask
  // Test clock cycle; inputs move after the fall
  task automatic tc(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    cyc(4);
    tbit = tdo;
    tck <= 1'b1;
    cyc(4);
    tck <= 1'b0;
    cyc(4);
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(86));
    cyc(16);
    rstn <= 1'b1;
    cyc(2);
    chk("done oe rst", done_oe, 1);
    chk("tdo oe rst", tdo_oe, 0);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl rst", rd, 32'h0010_0000);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    chk("status wr", er, 0);
    for (int i = 0; i < 5; i++) tc(1'b1, 1'b0);
    tc(1'b0, 1'b0);
    tc(1'b1, 1'b0);
    tc(1'b0, 1'b0);
    tc(1'b0, 1'b0);
    chk("tdo oe shift", tdo_oe, 1);
    for (int i = 0; i < 32; i++) begin
      tc(i == 31, 1'($urandom));
      id[i] = tbit;
    end
    chk("idcode", id, ID_C);
    tc(1'b1, 1'b0);
    tc(1'b0, 1'b0);
    chk("tdo oe idle", tdo_oe, 0);
    for (int w = 0; w < 6; w++) pass(3'(w), 0, w == 2);
    // Reload from user mode: pins ignored, image and width from the word
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 12'h000, {16'h0001, 9'h000, 2'(k + 1), 1'b1, 1'b0, 3'h2});
      u_fcp_host.frame(4, 1, 2 * k);
      if (k == 0) waitv(user, 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      chk("remote", {rd[30:28], rd[2]}, {1'b1, 2'(k + 1), k == 1});
    end
    pass(3'h1, 2, 1'b0);
    pass(3'h0, 1, 1'b0);
    mode_n <= 1'b1;
    foreach (act[i]) begin
      apb(1'b1, 12'h000, {16'h0001, 13'h0, act[i][2:0]});
      pulse();
      waitv(cclk_oe, 1'b1);
      cyc(8);
      chk("lane4 oe", lane_oe[4], act[i] == 3);
      cyc(80);
      chk("lane0 oe", lane_oe[0], act[i] == 0);
    end
    results();
  end
endmodule
